//--- verilog/sioc_status_io.sv
// Status flags, pin configuration and analog output code registers,
// reached through a 16-bit SPI slave.
// Assumes SPI mode 3 with a stall between frames before a read answer.
`timescale 1ns/1ps
`default_nettype none
`include "sioc_defines.svh"

module sioc_status_io #(
   parameter int DR_PULSE_CYC = `SIOC_DR_CYC
) (
   input  wire logic                 core_clk_i,
   input  wire logic                 rst_n_i,
   input  wire logic                 spi_sclk_i,
   input  wire logic                 spi_cs_n_i,
   input  wire logic                 spi_mosi_i,
   output logic                      spi_miso_o,
   input  wire sioc_pkg::sioc_cond_s cond_i,
   input  wire sioc_pkg::sioc_alarm_s alarm_i,
   input  wire logic                 sample_tick_i,
   input  wire logic                 data_ready_tick_i,
   input  wire logic                 supply_low_i,
   input  wire logic [3:0]           multi_pin_i,
   output logic      [3:0]           multi_pin_o,
   output logic      [3:0]           multi_pin_oe_o,
   output logic                      ext_clk_o,
   output logic      [11:0]          analog_code_o
);
   import sioc_pkg::*;

   generate
      if (DR_PULSE_CYC < 1 || DR_PULSE_CYC > 65535) begin : g_bad_pulse
         $error("Data-ready pulse count out of range");
      end
   endgenerate

   localparam logic [15:0] DR_LOAD = 16'(DR_PULSE_CYC);

   // =======================================================================
   // Link side: shift registers on the SPI clock
   logic [3:0]  bit_cnt_r;
   logic [3:0]  frame_base_r;
   logic [3:0]  bit_pos;
   logic [14:0] rx_sh_r;
   logic [15:0] rx_word_r;
   logic        word_tgl_r;
   logic        frame_err_tgl_r;
   logic [15:0] tx_sh_r;
   logic [15:0] tx_word_r;

   // Position in the current word; base is taken while the clock idles
   assign bit_pos = bit_cnt_r - frame_base_r;

   // Bit counter and receive shifter
   always_ff @(posedge spi_sclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         bit_cnt_r <= 4'h0;
         rx_sh_r   <= 15'h0000;
      end else begin
         bit_cnt_r <= bit_cnt_r + 4'h1;
         rx_sh_r   <= {rx_sh_r[13:0], spi_mosi_i};
      end
   end

   // Whole word handed over with a toggle; word holds for a full word time
   always_ff @(posedge spi_sclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rx_word_r  <= 16'h0000;
         word_tgl_r <= 1'b0;
      end else if (bit_pos == 4'hf) begin
         rx_word_r  <= {rx_sh_r, spi_mosi_i};
         word_tgl_r <= ~word_tgl_r;
      end
   end

   // Frame end checks the edge count against a multiple of 16
   always_ff @(posedge spi_cs_n_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         frame_base_r    <= 4'h0;
         frame_err_tgl_r <= 1'b0;
      end else begin
         frame_base_r <= bit_cnt_r;
         if (bit_cnt_r != frame_base_r) begin
            frame_err_tgl_r <= ~frame_err_tgl_r;
         end
      end
   end

   // Answer word loads on the first falling edge of each word
   always_ff @(negedge spi_sclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         tx_sh_r <= 16'h0000;
      end else if (bit_pos == 4'h0) begin
         tx_sh_r <= tx_word_r;
      end else begin
         tx_sh_r <= {tx_sh_r[14:0], 1'b0};
      end
   end

   assign spi_miso_o = tx_sh_r[15];

   // =======================================================================
   // Crossings into the core clock
   logic [1:0] word_sync_r;
   logic [1:0] err_sync_r;
   logic [1:0] supply_sync_r;
   logic [3:0] pin_meta_r;
   logic [3:0] pin_sync_r;
   logic       word_seen_r;
   logic       err_seen_r;
   logic       new_word;
   logic       frame_err;

   // Link toggles; only the toggle crosses, the word itself stands still
   always_ff @(posedge core_clk_i) begin
      if (!rst_n_i) begin
         word_sync_r <= 2'b00;
         err_sync_r  <= 2'b00;
         word_seen_r <= 1'b0;
         err_seen_r  <= 1'b0;
      end else begin
         word_sync_r <= {word_sync_r[0], word_tgl_r};
         err_sync_r  <= {err_sync_r[0], frame_err_tgl_r};
         word_seen_r <= word_sync_r[1];
         err_seen_r  <= err_sync_r[1];
      end
   end

   // Supply comparator level
   always_ff @(posedge core_clk_i) begin
      if (!rst_n_i) begin
         supply_sync_r <= 2'b00;
      end else begin
         supply_sync_r <= {supply_sync_r[0], supply_low_i};
      end
   end

   // Sensed pin levels
   always_ff @(posedge core_clk_i) begin
      if (!rst_n_i) begin
         pin_meta_r <= 4'h0;
         pin_sync_r <= 4'h0;
      end else begin
         pin_meta_r <= multi_pin_i;
         pin_sync_r <= pin_meta_r;
      end
   end

   assign new_word  = word_sync_r[1] ^ word_seen_r;
   assign frame_err = err_sync_r[1] ^ err_seen_r;

   // =======================================================================
   // Command decode
   sioc_cmd_s  cmd;
   logic [6:0] word_addr;
   logic       do_wr;
   logic       do_rd;

   assign cmd       = sioc_cmd_s'(rx_word_r);
   assign word_addr = {cmd.addr[6:1], 1'b0};
   assign do_wr     = new_word & cmd.wr;
   assign do_rd     = new_word & ~cmd.wr;

   // Byte write into a 16-bit register, unused bits held at zero
   function automatic logic [15:0] byte_wr(input logic [15:0] old_v,
                                           input logic        hi,
                                           input logic [7:0]  data,
                                           input logic [15:0] mask);
      logic [15:0] v;
      v = hi ? {data, old_v[7:0]} : {old_v[15:8], data};
      return v & mask;
   endfunction

   // =======================================================================
   // Configuration registers
   logic [15:0] aout_r;
   logic [15:0] pio_r;
   logic [15:0] misc_r;
   logic [15:0] smpl_r;

   // One byte per write; odd address is the high byte
   always_ff @(posedge core_clk_i) begin
      if (!rst_n_i) begin
         aout_r <= `SIOC_RST_AOUT;
         pio_r  <= `SIOC_RST_PIO;
         misc_r <= `SIOC_RST_MISC;
         smpl_r <= `SIOC_RST_SMPL;
      end else if (do_wr) begin
         if (word_addr == `SIOC_ADDR_AOUT) begin
            aout_r <= byte_wr(aout_r, cmd.addr[0], cmd.data, `SIOC_MASK_AOUT);
         end else if (word_addr == `SIOC_ADDR_PIO) begin
            pio_r <= byte_wr(pio_r, cmd.addr[0], cmd.data, `SIOC_MASK_PIO);
         end else if (word_addr == `SIOC_ADDR_MISC) begin
            misc_r <= byte_wr(misc_r, cmd.addr[0], cmd.data, `SIOC_MASK_MISC);
         end else if (word_addr == `SIOC_ADDR_SMPL) begin
            smpl_r <= byte_wr(smpl_r, cmd.addr[0], cmd.data, `SIOC_MASK_SMPL);
         end
      end
   end

   // Converter input register, loaded only by the latch command
   always_ff @(posedge core_clk_i) begin
      if (!rst_n_i) begin
         analog_code_o <= 12'h000;
      end else if (do_wr && cmd.addr == `SIOC_ADDR_GCMD
                   && cmd.data[`SIOC_BIT_LATCH]) begin
         analog_code_o <= aout_r[11:0];
      end
   end

   // =======================================================================
   // Diagnostic flags
   logic [15:0] diag_r;
   logic [15:0] diag_set;
   logic [15:0] diag_nxt;
   logic        diag_clr;

   assign diag_clr = do_rd && word_addr == `SIOC_ADDR_DIAG;

   always_comb begin
      diag_set = 16'h0000;
      if (sample_tick_i) begin
         diag_set[`SIOC_BIT_ST0 +: 6]  = cond_i.st_fail;
         diag_set[`SIOC_BIT_ALM1 +: 2] = cond_i.alarm;
         diag_set[`SIOC_BIT_CSUM]      = cond_i.checksum;
         diag_set[`SIOC_BIT_STANY]     = cond_i.st_any;
         diag_set[`SIOC_BIT_OVR]       = cond_i.overrange;
         diag_set[`SIOC_BIT_FLASH]     = cond_i.flash_fail;
      end
      diag_set[`SIOC_BIT_SPI] = frame_err;
   end

   // Set beats the clearing read; supply bit is a plain level
   always_comb begin
      diag_nxt = (diag_clr ? 16'h0000 : diag_r) | diag_set;
      diag_nxt[`SIOC_BIT_SUPPLY] = supply_sync_r[1];
      diag_nxt = diag_nxt & `SIOC_MASK_DIAG;
   end

   always_ff @(posedge core_clk_i) begin
      if (!rst_n_i) begin
         diag_r <= `SIOC_RST_DIAG;
      end else begin
         diag_r <= diag_nxt;
      end
   end

   // =======================================================================
   // Read answer, shifted out during the next word
   logic [3:0]  lvl_seen;
   logic [15:0] rd_data;

   for (genvar p = 0; p < 4; p++) begin : g_lvl
      assign lvl_seen[p] = pio_r[p] ? pio_r[`SIOC_BIT_LVL0 + p] : pin_sync_r[p];
   end

   always_comb begin
      if (word_addr == `SIOC_ADDR_AOUT) begin
         rd_data = aout_r;
      end else if (word_addr == `SIOC_ADDR_PIO) begin
         rd_data = {4'h0, lvl_seen, 4'h0, pio_r[3:0]};
      end else if (word_addr == `SIOC_ADDR_MISC) begin
         rd_data = misc_r;
      end else if (word_addr == `SIOC_ADDR_SMPL) begin
         rd_data = smpl_r;
      end else if (word_addr == `SIOC_ADDR_DIAG) begin
         rd_data = diag_r;
      end else begin
         rd_data = 16'h0000;
      end
   end

   // Answer stands until the next read replaces it
   always_ff @(posedge core_clk_i) begin
      if (!rst_n_i) begin
         tx_word_r <= 16'h0000;
      end else if (do_rd) begin
         tx_word_r <= rd_data;
      end
   end

   // =======================================================================
   // Data-ready pulse timer
   logic [15:0] dr_cnt_r;
   logic        dr_active;

   // A new tick restarts the pulse, so close ticks stretch it
   always_ff @(posedge core_clk_i) begin
      if (!rst_n_i) begin
         dr_cnt_r <= 16'h0000;
      end else if (data_ready_tick_i) begin
         dr_cnt_r <= DR_LOAD;
      end else if (dr_cnt_r != 16'h0000) begin
         dr_cnt_r <= dr_cnt_r - 16'h0001;
      end
   end

   assign dr_active = dr_cnt_r != 16'h0000;

   // =======================================================================
   // Pin ownership
   logic [3:0] pin_lvl;
   logic [3:0] pin_oe;
   logic       dr_level;
   logic       ext_sel;

   assign dr_level = misc_r[`SIOC_BIT_DR_POL] ? dr_active : ~dr_active;
   assign ext_sel  = ~smpl_r[`SIOC_BIT_INT_CLK];

   always_comb begin
      pin_oe  = pio_r[3:0];
      pin_lvl = pio_r[`SIOC_BIT_LVL0 +: 4];
      for (int p = 0; p < 2; p++) begin
         if (misc_r[`SIOC_BIT_DR_EN] && misc_r[`SIOC_BIT_DR_SEL] == p[0]) begin
            pin_oe[p]  = 1'b1;
            pin_lvl[p] = dr_level;
         end else if (alarm_i.en && alarm_i.sel == p[0]) begin
            pin_oe[p]  = 1'b1;
            pin_lvl[p] = alarm_i.level;
         end
      end
      if (ext_sel) begin
         pin_oe[3]  = 1'b0;
         pin_lvl[3] = 1'b0;
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (!rst_n_i) begin
         multi_pin_o    <= 4'h0;
         multi_pin_oe_o <= 4'h0;
      end else begin
         multi_pin_o    <= pin_lvl & pin_oe;
         multi_pin_oe_o <= pin_oe;
      end
   end

   // Pin 4 passed on as the external sample clock
   always_ff @(posedge core_clk_i) begin
      if (!rst_n_i) begin
         ext_clk_o <= 1'b0;
      end else begin
         ext_clk_o <= ext_sel & pin_sync_r[3];
      end
   end

endmodule
`default_nettype wire

//--- verilog/sioc_defines.svh
// Constants of the status and pin configuration block: offsets, masks,
// reset values and timing counts.
// Assumes a 125 MHz core clock and 16-bit SPI command words.
//
// Summary of operation
// - Each diagnostic flag reads 1 for an error, 0 when normal.
// - Reading the diagnostic flags returns them, then clears all flags except bit 0.
// - A persisting condition sets its flag again at the next sample end.
// - Bit 0 follows the supply-low comparator; clears itself when supply recovers.
// - Bit 3 sets when a framed transfer's clock count is not a multiple of 16.
// - Bits 15 to 10 are self-test fails: accel Z, Y, X, gyro Z, Y, X.
// - Bit 9 reports alarm 2, bit 8 reports alarm 1.
// - Bit 6 checksum mismatch, bit 5 any self-test fail, bit 4 overrange.
// - Bit 2 flags a failed flash update; bits 7 and 1 unused.
// - Default data-ready setting 110 gives an active-high pulse on pin 1.
// - Setting 100 keeps data-ready on pin 1 but active low.
// - Data-ready pulse lasts between 40 and 80 microseconds, set by a timer.
// - Pins 1 and 2: data-ready first, then alarm, then general-purpose control.
// - External sample clock use of pin 4 overrides general-purpose settings.
// - Pin 3 is driven only by general-purpose direction and level bits.
// - Pin control bits 3 to 0 set direction of pins 4 to 1; 1 output.
// - Bits 11 to 8 drive output levels and read back input levels.
// - Command 0x3200 reads pin levels; host masks unwatched bits.
// - Analog output code is 12 bits, offset binary, 0.8059 mV per step.
// - Code byte writes wait; latch bit 2 of global command copies both.
// - Misc-control bit 2 enables data-ready, bit 1 polarity, bit 0 pin.
`ifndef SIOC_DEFINES_SVH
`define SIOC_DEFINES_SVH

// ==========================================================================
// Register byte addresses
`define SIOC_ADDR_AOUT      7'h30
`define SIOC_ADDR_PIO       7'h32
`define SIOC_ADDR_MISC      7'h34
`define SIOC_ADDR_SMPL      7'h36
`define SIOC_ADDR_DIAG      7'h3c
`define SIOC_ADDR_GCMD      7'h3e

// ==========================================================================
// Implemented-bit masks and reset values
`define SIOC_MASK_AOUT      16'h0fff
`define SIOC_MASK_PIO       16'h0f0f
`define SIOC_MASK_MISC      16'h0dc7
`define SIOC_MASK_SMPL      16'h1f01
`define SIOC_MASK_DIAG      16'hff7d
`define SIOC_RST_AOUT       16'h0000
`define SIOC_RST_PIO        16'h0000
`define SIOC_RST_MISC       16'h0006
`define SIOC_RST_SMPL       16'h0001
`define SIOC_RST_DIAG       16'h0000

// ==========================================================================
// Field positions
`define SIOC_BIT_SUPPLY     0
`define SIOC_BIT_FLASH      2
`define SIOC_BIT_SPI        3
`define SIOC_BIT_OVR        4
`define SIOC_BIT_STANY      5
`define SIOC_BIT_CSUM       6
`define SIOC_BIT_ALM1       8
`define SIOC_BIT_ST0        10
`define SIOC_BIT_DR_SEL     0
`define SIOC_BIT_DR_POL     1
`define SIOC_BIT_DR_EN      2
`define SIOC_BIT_INT_CLK    0
`define SIOC_BIT_LATCH      2
`define SIOC_BIT_LVL0       8

// ==========================================================================
// Timing
`define SIOC_CLK_MHZ        125
`define SIOC_DR_MIN_US      40
`define SIOC_DR_MAX_US      80
`define SIOC_DR_CYC         (((`SIOC_DR_MIN_US + `SIOC_DR_MAX_US) / 2) * `SIOC_CLK_MHZ)

`endif

//--- verilog/sioc_pkg.sv
// Types of the status and pin configuration block.
// Assumes the constants header is included by the design file.
package sioc_pkg;

   // Condition levels from sensor, alarm and flash logic
   typedef struct packed {
      logic [5:0] st_fail;
      logic [1:0] alarm;
      logic       checksum;
      logic       st_any;
      logic       overrange;
      logic       flash_fail;
   } sioc_cond_s;

   // One received SPI command word
   typedef struct packed {
      logic       wr;
      logic [6:0] addr;
      logic [7:0] data;
   } sioc_cmd_s;

   // Alarm logic's claim on pins 1 and 2
   typedef struct packed {
      logic en;
      logic sel;
      logic level;
   } sioc_alarm_s;

endpackage

//--- bench/sioc_spi_host.sv
// SPI master model standing in for the host processor.
// Assumes mode 3, 30 ns link clock, MSB first, one word per call.
`timescale 1ns/1ps
`default_nettype none

module sioc_spi_host (
   output logic      spi_sclk_o,
   output logic      spi_cs_n_o,
   output logic      spi_mosi_o,
   input  wire logic spi_miso_i
);
   initial begin
      spi_sclk_o = 1'b1;
      spi_cs_n_o = 1'b1;
      spi_mosi_o = 1'b0;
   end

   // ======================================================================
   // One framed transfer of n clocks; clock stands still outside frames
   task automatic xfer(input logic [15:0] w, input int n, output logic [15:0] r);
      r = 16'h0000;
      spi_cs_n_o = 1'b0;
      #20;
      for (int i = 0; i < n; i++) begin
         spi_sclk_o = 1'b0;
         spi_mosi_o = w[15-i];
         #15;
         spi_sclk_o = 1'b1;
         r = {r[14:0], spi_miso_i};
         #15;
      end
      spi_cs_n_o = 1'b1;
      // Released line shows no stale data
      spi_mosi_o = ~spi_mosi_o;
      // Gap well above the 24 ns (three core cycles) the answer needs
      #100;
   endtask
endmodule

`default_nettype wire

//--- bench/sioc_status_io_chk.sv
// Port-level checks on the status and pin configuration block.
// Assumes binding to sioc_status_io; core clock domain only.
`timescale 1ns/1ps
`default_nettype none

module sioc_status_io_chk (
   input wire logic        core_clk_i,
   input wire logic        rst_n_i,
   input wire logic        spi_cs_n_i,
   input wire logic [3:0]  multi_pin_i,
   input wire logic [3:0]  multi_pin_o,
   input wire logic [3:0]  multi_pin_oe_o,
   input wire logic        ext_clk_o,
   input wire logic [11:0] analog_code_o
);
   default clocking cb @(posedge core_clk_i);
   endclocking
   default disable iff (!rst_n_i);

   // ======================================================================
   // Properties
   // Link quiet long enough for any command to have landed
   sequence s_idle;
      spi_cs_n_i [*8];
   endsequence
   sequence s_release;
      $rose(rst_n_i);
   endsequence

   property p_code_hold;
      s_idle |=> $stable(analog_code_o);
   endproperty
   property p_pin3_quiet;
      s_idle |=> $stable({multi_pin_oe_o[2], multi_pin_o[2]});
   endproperty
   property p_pin4_quiet;
      s_idle |=> $stable(multi_pin_oe_o[3]);
   endproperty
   property p_reset_clear;
      s_release |-> analog_code_o == 12'h000 && multi_pin_oe_o == 4'h0 && !ext_clk_o;
   endproperty
   property p_dr_default;
      s_release |-> ##[1:4] (multi_pin_oe_o[0] && !multi_pin_o[0]);
   endproperty
   property p_ext_no_drive;
      ext_clk_o |-> !multi_pin_oe_o[3];
   endproperty
   property p_ext_follow;
      $rose(ext_clk_o) |-> $past(multi_pin_i[3], 3);
   endproperty
   property p_undriven_low;
      (multi_pin_o & ~multi_pin_oe_o) == 4'h0;
   endproperty

   a_code_hold: assert property (p_code_hold)
      else $error("analog code moved with link idle");
   a_pin3_quiet: assert property (p_pin3_quiet)
      else $error("pin 3 moved with link idle");
   a_pin4_quiet: assert property (p_pin4_quiet)
      else $error("pin 4 enable moved with link idle");
   a_reset_clear: assert property (p_reset_clear)
      else $error("outputs not cleared by reset");
   a_dr_default: assert property (p_dr_default)
      else $error("pin 1 not idle data-ready after reset");
   a_ext_no_drive: assert property (p_ext_no_drive)
      else $error("pin 4 driven in external clock use");
   a_ext_follow: assert property (p_ext_follow)
      else $error("external clock rose without pin 4");
   a_undriven_low: assert property (p_undriven_low)
      else $error("level on an undriven pin");
endmodule

bind sioc_status_io sioc_status_io_chk i_chk (
   .core_clk_i    (core_clk_i),
   .rst_n_i       (rst_n_i),
   .spi_cs_n_i    (spi_cs_n_i),
   .multi_pin_i   (multi_pin_i),
   .multi_pin_o   (multi_pin_o),
   .multi_pin_oe_o(multi_pin_oe_o),
   .ext_clk_o     (ext_clk_o),
   .analog_code_o (analog_code_o)
);

`default_nettype wire

//--- bench/status_io_config_block_test.sv
// Self-checking bench of the status and pin configuration block.
// Assumes the SPI host model and checker files are compiled with it.
`timescale 1ns/1ps
`default_nettype none

module status_io_config_block_test;
   import sioc_pkg::*;

   logic        core_clk_i, rst_n_i, spi_sclk_i, spi_cs_n_i, spi_mosi_i, spi_miso_o;
   logic        sample_tick_i, data_ready_tick_i, supply_low_i, ext_clk_o;
   logic [3:0]  multi_pin_i, multi_pin_o, multi_pin_oe_o;
   logic [11:0] analog_code_o;
   sioc_cond_s  cond_i;
   sioc_alarm_s alarm_i;
   int          n_errors = 0;
   int          compares = 0;

   sioc_status_io #(.DR_PULSE_CYC(20)) i_dut (
      .core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .spi_sclk_i(spi_sclk_i),
      .spi_cs_n_i(spi_cs_n_i), .spi_mosi_i(spi_mosi_i), .spi_miso_o(spi_miso_o),
      .cond_i(cond_i), .alarm_i(alarm_i), .sample_tick_i(sample_tick_i),
      .data_ready_tick_i(data_ready_tick_i), .supply_low_i(supply_low_i),
      .multi_pin_i(multi_pin_i), .multi_pin_o(multi_pin_o),
      .multi_pin_oe_o(multi_pin_oe_o), .ext_clk_o(ext_clk_o),
      .analog_code_o(analog_code_o));
   sioc_spi_host i_host (.spi_sclk_o(spi_sclk_i), .spi_cs_n_o(spi_cs_n_i),
      .spi_mosi_o(spi_mosi_i), .spi_miso_i(spi_miso_o));

   initial begin
      core_clk_i = 1'b0;
      forever #4 core_clk_i = ~core_clk_i;
   end

   // ======================================================================
   // Shared tasks
   task automatic cyc(input int n);
      repeat (n) @(posedge core_clk_i);
      #1;
   endtask
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      compares++;
      if (got !== exp) begin
         n_errors++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [6:0] a, input logic [7:0] d);
      logic [15:0] r;
      i_host.xfer({1'b1, a, d}, 16, r);
      cyc(1);
   endtask
   // Answer comes out during the following word
   task automatic rdc(input logic [6:0] a, input logic [15:0] exp);
      logic [15:0] r;
      i_host.xfer({1'b0, a, 8'h00}, 16, r);
      i_host.xfer(16'h0000, 16, r);
      cyc(1);
      chk(r, exp);
   endtask
   task automatic tick();
      sample_tick_i = 1'b1;
      cyc(1);
      sample_tick_i = 1'b0;
   endtask
   task automatic dr_pulse(input logic act);
      int n = 0;
      chk({15'h0, multi_pin_o[0]}, {15'h0, ~act});
      data_ready_tick_i = 1'b1;
      cyc(1);
      data_ready_tick_i = 1'b0;
      repeat (4) if (multi_pin_o[0] !== act) cyc(1);
      while (multi_pin_o[0] === act && n < 100) begin
         n++;
         cyc(1);
      end
      chk(n[15:0], 16'h0014);
   endtask
   task automatic end_sim();
      $display("errors %0d, compares %0d", n_errors, compares);
      if (n_errors == 0 && compares > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   // ======================================================================
   // Scenarios
   task automatic t_reset();
      rdc(7'h30, 16'h0000);
      rdc(7'h32, 16'h0000);
      rdc(7'h34, 16'h0006);
      rdc(7'h3c, 16'h0000);
      rdc(7'h40, 16'h0000);
   endtask
   task automatic t_flags();
      for (int i = 0; i < 12; i++) begin
         cond_i = 12'h001 << i;
         tick();
         cond_i = '0;
         rdc(7'h3c, 16'h0001 << (i == 0 ? 2 : (i < 4 ? i + 3 : i + 4)));
      end
      cond_i = 12'hfff;
      supply_low_i = 1'b1;
      tick();
      rdc(7'h3c, 16'hff75);
      cond_i = 12'h010;
      rdc(7'h3c, 16'h0001);
      tick();
      rdc(7'h3c, 16'h0101);
      supply_low_i = 1'b0;
      cond_i = '0;
      cyc(5);
      rdc(7'h3c, 16'h0000);
   endtask
   task automatic t_spi_err();
      logic [15:0] r;
      i_host.xfer(16'h0000, 12, r);
      cyc(1);
      rdc(7'h3c, 16'h0008);
   endtask
   task automatic t_pins();
      multi_pin_i = 4'hb;
      wr(7'h32, 8'h04);
      wr(7'h33, 8'hf4);
      chk({14'h0, multi_pin_oe_o[2], multi_pin_o[2]}, 16'h0003);
      rdc(7'h32, 16'h0f04);
      wr(7'h32, 8'h0c);
      wr(7'h33, 8'h08);
      chk({8'h0, multi_pin_oe_o, multi_pin_o}, 16'h00d8);
      wr(7'h36, 8'h00);
      chk({7'h0, ext_clk_o, multi_pin_oe_o, multi_pin_o}, 16'h0150);
      multi_pin_i = 4'h3;
      cyc(5);
      chk({15'h0, ext_clk_o}, 16'h0000);
      multi_pin_i = 4'hb;
      cyc(5);
      chk({15'h0, ext_clk_o}, 16'h0001);
      wr(7'h36, 8'h01);
   endtask
   task automatic t_dr();
      dr_pulse(1'b1);
      wr(7'h34, 8'h04);
      dr_pulse(1'b0);
      alarm_i = 3'b100;
      cyc(3);
      chk({12'h0, multi_pin_oe_o[1:0], multi_pin_o[1:0]}, 16'h0005);
      wr(7'h34, 8'h00);
      chk({12'h0, multi_pin_oe_o[1:0], multi_pin_o[1:0]}, 16'h0004);
      alarm_i = 3'b000;
      cyc(3);
      chk({12'h0, multi_pin_oe_o[1:0], multi_pin_o[1:0]}, 16'h0000);
      wr(7'h34, 8'h07);
      chk({12'h0, multi_pin_oe_o[1:0], multi_pin_o[1:0]}, 16'h0008);
      alarm_i = 3'b111;
      cyc(3);
      chk({12'h0, multi_pin_oe_o[1:0], multi_pin_o[1:0]}, 16'h0008);
      wr(7'h34, 8'h06);
      chk({12'h0, multi_pin_oe_o[1:0], multi_pin_o[1:0]}, 16'h000e);
      alarm_i = 3'b000;
   endtask
   task automatic t_aout();
      wr(7'h30, 8'hd9);
      wr(7'h31, 8'hf4);
      chk({4'h0, analog_code_o}, 16'h0000);
      rdc(7'h30, 16'h04d9);
      wr(7'h3e, 8'h04);
      chk({4'h0, analog_code_o}, 16'h04d9);
   endtask

   // ======================================================================
   // Main sequence and watchdog
   initial begin
      rst_n_i = 1'b0;
      cond_i = '0;
      alarm_i = '0;
      sample_tick_i = 1'b0;
      data_ready_tick_i = 1'b0;
      supply_low_i = 1'b0;
      multi_pin_i = 4'h0;
      cyc(5);
      rst_n_i = 1'b1;
      cyc(4);
      t_reset();
      t_flags();
      t_spi_err();
      t_pins();
      t_dr();
      t_aout();
      end_sim();
   end
   initial begin
      #500000;
      n_errors++;
      end_sim();
   end
endmodule

`default_nettype wire
